// [core/rcc_pkg.sv]
// constants, register map and state codes of the reset and clock control
package rcc_pkg;
  // ********************
  // timing
  // ********************
  localparam int CLK_MHZ = 10;
  localparam int REL_NS  = 400;
  localparam int REL_CYC = (REL_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W   = 4;

  // ********************
  // register offsets
  // ********************
  localparam logic [7:0]      BRC_OFF   = 8'h00;
  localparam logic [7:0]      CAUSE_OFF = 8'h04;
  localparam logic [7:0]      RCFG_OFF  = 8'h08;
  localparam logic [7:0]      RCFG2_OFF = 8'h0C;
  localparam logic [2:0][7:0] SRST_OFF  = {8'h18, 8'h14, 8'h10};
  localparam logic [2:0][7:0] GATE_OFF  = {8'h24, 8'h20, 8'h1C};
  localparam logic [7:0]      WLOAD_OFF = 8'h28;
  localparam logic [7:0]      WCTL_OFF  = 8'h2C;
  localparam logic [7:0]      STAT_OFF  = 8'h30;
  localparam logic [7:0]      WVAL_OFF  = 8'h34;
  localparam logic [7:0]      PLLC_OFF  = 8'h38;

  // ********************
  // fields and reset values
  // ********************
  localparam int NREG     = 3;
  localparam int NP_W     = 96;
  localparam int BOR_SEL  = 1;
  localparam int CAU_W    = 5;
  localparam int CAU_EXT  = 0;
  localparam int CAU_POR  = 1;
  localparam int CAU_BOR  = 2;
  localparam int CAU_WDT  = 3;
  localparam int CAU_SW   = 4;
  localparam int OSC_LSB  = 4;
  localparam int OSC_W    = 2;
  localparam int OSC2_W   = 3;
  localparam int CRYSTAL_SELECT_LSB = 6;
  localparam int CRYSTAL_SELECT_W   = 5;
  localparam int BYP_BIT  = 11;
  localparam int PDN_BIT  = 13;
  localparam int OVR_BIT  = 31;
  localparam int WEN_BIT  = 0;
  localparam int WRST_BIT = 1;
  localparam int S_WINT   = 0;
  localparam int S_BINT   = 1;
  localparam int PLLC_W   = 14;
  localparam logic [CAU_W-1:0] CAUSE_RST = 5'h02;
  localparam logic [31:0] RCFG_RST  = 32'h0000_2810;
  localparam logic [31:0] WLOAD_RST = 32'hFFFF_FFFF;
  localparam logic [8:0]  PLL_F_BASE = 9'h0C8;

  // ********************
  // clock sources
  // ********************
  localparam logic [2:0] SRC_MAIN = 3'h0;
  localparam logic [2:0] SRC_INT  = 3'h1;
  localparam logic [2:0] SRC_INT4 = 3'h2;
  localparam logic [2:0] SRC_30K  = 3'h3;
  localparam logic [2:0] SRC_RTC  = 3'h4;
  localparam logic [2:0] SRC_PLL  = 3'h5;
  localparam logic [2:0] OSC2_RTC = 3'h7;
  localparam int PLL_OUT_MHZ = 400;
  localparam int ADC_MHZ     = 16;
  localparam logic [7:0] ADC_PLL_DIV = 8'(PLL_OUT_MHZ / ADC_MHZ);
  localparam logic [7:0] ADC_RAW_DIV = 8'h01;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HOLD = 3'b010,
    ST_REL  = 3'b100
  } rst_state_t;
endpackage

// [core/reset_and_clock_control.sv]
// reset gathering, reset sequencing and system clock steering with apb access
`timescale 1ns/100ps
module reset_and_clock_control (
  input  wire logic                      CLK_I,
  input  wire logic                      RST_I,
  input  wire logic                      CE_I,
  input  wire logic                      EXT_RST_N_I,
  input  wire logic                      BOR_DET_I,
  input  wire logic                      SYS_RESET_REQ_I,
  input  wire logic                      PLL_LOCK_I,
  input  wire logic                      PSEL_I,
  input  wire logic                      PENABLE_I,
  input  wire logic                      PWRITE_I,
  input  wire logic [7:0]                PADDR_I,
  input  wire logic [31:0]               PWDATA_I,
  output logic      [31:0]               PRDATA_O,
  output logic                           PREADY_O,
  output logic                           PSLVERR_O,
  output logic                           SYS_RST_O,
  output logic      [rcc_pkg::NP_W-1:0]  PERIPH_RST_O,
  output logic      [rcc_pkg::NP_W-1:0]  PERIPH_CLK_EN_O,
  output logic      [2:0]                CORE_SYSTEM_CLOCK_SRC_O,
  output logic      [7:0]                ADC_CLK_DIV_O,
  output logic      [rcc_pkg::PLLC_W-1:0] PLL_CFG_O,
  output logic                           BOR_IRQ_O,
  output logic                           WDT_IRQ_O
);

  // ********************
  // state
  // ********************
  typedef struct packed {
    rcc_pkg::rst_state_t              st;
    logic [rcc_pkg::CNT_W-1:0]        cnt;
    logic                             bor_sel;
    logic                             bor_prev;
    logic                             bint;
    logic [rcc_pkg::CAU_W-1:0]        cause;
    logic [31:0]                      rcfg;
    logic [31:0]                      rcfg2;
    logic [rcc_pkg::NREG-1:0][31:0]   srst;
    logic [rcc_pkg::NREG-1:0][31:0]   gate;
    logic [31:0]                      wload;
    logic [31:0]                      wcnt;
    logic                             wen;
    logic                             wren;
    logic                             wint;
    logic                             wfire;
    logic [2:0]                       src;
    logic [7:0]                       adcdiv;
    logic [rcc_pkg::PLLC_W-1:0]       pllc;
    logic [31:0]                      rdata;
  } st_t;

  localparam st_t ST_RESET = '{
    st:       rcc_pkg::ST_REL,
    cnt:      rcc_pkg::CNT_W'(rcc_pkg::REL_CYC - 1),
    bor_sel:  1'b0,
    bor_prev: 1'b0,
    bint:     1'b0,
    cause:    rcc_pkg::CAUSE_RST,
    rcfg:     rcc_pkg::RCFG_RST,
    rcfg2:    rcc_pkg::RCFG_RST,
    srst:     '0,
    gate:     '0,
    wload:    rcc_pkg::WLOAD_RST,
    wcnt:     rcc_pkg::WLOAD_RST,
    wen:      1'b0,
    wren:     1'b0,
    wint:     1'b0,
    wfire:    1'b0,
    src:      rcc_pkg::SRC_INT,
    adcdiv:   rcc_pkg::ADC_RAW_DIV,
    pllc:     '0,
    rdata:    '0
  };

  st_t  q;
  st_t  n;
  logic acc;
  logic wr;
  logic sys_rst;
  logic bor_rst;
  logic src_any;
  logic mapped;

  // ********************
  // helpers
  // ********************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  function automatic logic [rcc_pkg::PLLC_W-1:0] pll_cfg(
    input logic [rcc_pkg::CRYSTAL_SELECT_W-1:0] x
  );
    logic [8:0] f;
    f = rcc_pkg::PLL_F_BASE - {4'h0, x};
    return {x, f};
  endfunction

  function automatic logic [2:0] pick_src(
    input logic [31:0] c,
    input logic [31:0] c2,
    input logic        lock
  );
    logic       ovr;
    logic       byp;
    logic       pdn;
    logic [2:0] osc;
    ovr = c2[rcc_pkg::OVR_BIT];
    osc = ovr ? c2[rcc_pkg::OSC_LSB +: rcc_pkg::OSC2_W]
              : {1'b0, c[rcc_pkg::OSC_LSB +: rcc_pkg::OSC_W]};
    if (osc == rcc_pkg::OSC2_RTC) begin
      osc = rcc_pkg::SRC_RTC;
    end else if (osc > rcc_pkg::SRC_30K) begin
      osc = rcc_pkg::SRC_INT;
    end
    byp = ovr ? c2[rcc_pkg::BYP_BIT] : c[rcc_pkg::BYP_BIT];
    pdn = ovr ? c2[rcc_pkg::PDN_BIT] : c[rcc_pkg::PDN_BIT];
    return (!byp && !pdn && lock) ? rcc_pkg::SRC_PLL : osc;
  endfunction

  // ********************
  // combinational decode
  // ********************
  assign acc     = PSEL_I & PENABLE_I & CE_I;
  assign wr      = acc & PWRITE_I;
  assign sys_rst = q.st != rcc_pkg::ST_RUN;
  assign bor_rst = BOR_DET_I & q.bor_sel;
  assign src_any = !EXT_RST_N_I | bor_rst | SYS_RESET_REQ_I | q.wfire;

  always_comb begin
    logic        wset;
    logic [31:0] rv;
    n      = q;
    wset   = 1'b0;
    rv     = '0;
    mapped = 1'b1;

    // read mux
    if (hit(PADDR_I, rcc_pkg::BRC_OFF)) begin
      rv[rcc_pkg::BOR_SEL] = q.bor_sel;
    end else if (hit(PADDR_I, rcc_pkg::CAUSE_OFF)) begin
      rv[rcc_pkg::CAU_W-1:0] = q.cause;
    end else if (hit(PADDR_I, rcc_pkg::RCFG_OFF)) begin
      rv = q.rcfg;
    end else if (hit(PADDR_I, rcc_pkg::RCFG2_OFF)) begin
      rv = q.rcfg2;
    end else if (hit(PADDR_I, rcc_pkg::WLOAD_OFF)) begin
      rv = q.wload;
    end else if (hit(PADDR_I, rcc_pkg::WCTL_OFF)) begin
      rv[rcc_pkg::WEN_BIT]  = q.wen;
      rv[rcc_pkg::WRST_BIT] = q.wren;
    end else if (hit(PADDR_I, rcc_pkg::STAT_OFF)) begin
      rv[rcc_pkg::S_WINT] = q.wint;
      rv[rcc_pkg::S_BINT] = q.bint;
    end else if (hit(PADDR_I, rcc_pkg::WVAL_OFF)) begin
      rv = q.wcnt;
    end else if (hit(PADDR_I, rcc_pkg::PLLC_OFF)) begin
      rv[rcc_pkg::PLLC_W-1:0] = q.pllc;
    end else begin
      mapped = 1'b0;
    end
    for (int i = 0; i < rcc_pkg::NREG; i++) begin
      if (hit(PADDR_I, rcc_pkg::SRST_OFF[i])) begin
        rv     = q.srst[i];
        mapped = 1'b1;
      end
      if (hit(PADDR_I, rcc_pkg::GATE_OFF[i])) begin
        rv     = q.gate[i];
        mapped = 1'b1;
      end
    end
    if (PSEL_I && !PENABLE_I) begin
      n.rdata = rv;
    end

    // watchdog down-counter
    n.wfire = 1'b0;
    if (q.wen) begin
      if (q.wcnt == '0) begin
        n.wcnt = q.wload;
        if (!q.wint) begin
          wset = 1'b1;
        end else if (q.wren) begin
          n.wfire = 1'b1;
        end
      end else begin
        n.wcnt = q.wcnt - 32'h0000_0001;
      end
    end

    // register writes
    if (wr) begin
      if (hit(PADDR_I, rcc_pkg::BRC_OFF)) begin
        n.bor_sel = PWDATA_I[rcc_pkg::BOR_SEL];
      end
      if (hit(PADDR_I, rcc_pkg::CAUSE_OFF)) begin
        n.cause = PWDATA_I[rcc_pkg::CAU_W-1:0];
      end
      if (hit(PADDR_I, rcc_pkg::RCFG_OFF)) begin
        n.rcfg = PWDATA_I;
      end
      if (hit(PADDR_I, rcc_pkg::RCFG2_OFF)) begin
        n.rcfg2 = PWDATA_I;
      end
      for (int i = 0; i < rcc_pkg::NREG; i++) begin
        if (hit(PADDR_I, rcc_pkg::SRST_OFF[i])) begin
          n.srst[i] = PWDATA_I;
        end
        if (hit(PADDR_I, rcc_pkg::GATE_OFF[i])) begin
          n.gate[i] = PWDATA_I;
        end
      end
      if (hit(PADDR_I, rcc_pkg::WLOAD_OFF)) begin
        n.wload = PWDATA_I;
        n.wcnt  = PWDATA_I;
      end
      if (hit(PADDR_I, rcc_pkg::WCTL_OFF)) begin
        n.wen  = PWDATA_I[rcc_pkg::WEN_BIT];
        n.wren = PWDATA_I[rcc_pkg::WRST_BIT];
      end
      if (hit(PADDR_I, rcc_pkg::STAT_OFF)) begin
        if (PWDATA_I[rcc_pkg::S_WINT]) begin
          n.wint = 1'b0;
        end
        if (PWDATA_I[rcc_pkg::S_BINT]) begin
          n.bint = 1'b0;
        end
      end
    end

    // hardware events win over software clears
    if (wset) begin
      n.wint = 1'b1;
    end
    n.bor_prev = BOR_DET_I;
    if (BOR_DET_I && !q.bor_prev && !q.bor_sel) begin
      n.bint = 1'b1;
    end
    if (!EXT_RST_N_I) begin
      n.cause[rcc_pkg::CAU_EXT] = 1'b1;
    end
    if (bor_rst) begin
      n.cause[rcc_pkg::CAU_BOR] = 1'b1;
    end
    if (SYS_RESET_REQ_I) begin
      n.cause[rcc_pkg::CAU_SW] = 1'b1;
    end
    if (q.wfire) begin
      n.cause[rcc_pkg::CAU_WDT] = 1'b1;
    end

    // reset sequencer
    unique case (q.st)
      rcc_pkg::ST_RUN: begin
        if (src_any) begin
          n.st = rcc_pkg::ST_HOLD;
        end
      end
      rcc_pkg::ST_HOLD: begin
        if (!src_any) begin
          n.st  = rcc_pkg::ST_REL;
          n.cnt = rcc_pkg::CNT_W'(rcc_pkg::REL_CYC - 1);
        end
      end
      rcc_pkg::ST_REL: begin
        if (src_any) begin
          n.st = rcc_pkg::ST_HOLD;
        end else if (q.cnt == '0) begin
          n.st = rcc_pkg::ST_RUN;
        end else begin
          n.cnt = q.cnt - rcc_pkg::CNT_W'(1);
        end
      end
    endcase

    // system reset returns control state except the brownout select, brownout flag and cause to defaults
    if (sys_rst) begin
      n.rcfg  = rcc_pkg::RCFG_RST;
      n.rcfg2 = rcc_pkg::RCFG_RST;
      n.srst  = '0;
      n.gate  = '0;
      n.wload = rcc_pkg::WLOAD_RST;
      n.wcnt  = rcc_pkg::WLOAD_RST;
      n.wen   = 1'b0;
      n.wren  = 1'b0;
      n.wint  = 1'b0;
      n.wfire = 1'b0;
    end

    // clock steering
    if (n.st != rcc_pkg::ST_RUN) begin
      n.src = rcc_pkg::SRC_INT;
    end else begin
      n.src = pick_src(n.rcfg, n.rcfg2, PLL_LOCK_I);
    end
    n.adcdiv = (n.src == rcc_pkg::SRC_PLL) ? rcc_pkg::ADC_PLL_DIV
                                           : rcc_pkg::ADC_RAW_DIV;
    n.pllc = pll_cfg(n.rcfg[rcc_pkg::CRYSTAL_SELECT_LSB +: rcc_pkg::CRYSTAL_SELECT_W]);
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q <= ST_RESET;
    end else if (CE_I) begin
      q <= n;
    end
  end

  // ********************
  // outputs
  // ********************
  assign PRDATA_O        = q.rdata;
  assign PREADY_O        = CE_I;
  assign PSLVERR_O       = acc & !mapped;
  assign SYS_RST_O       = sys_rst;
  assign PERIPH_RST_O    = q.srst | {rcc_pkg::NP_W{sys_rst}};
  assign PERIPH_CLK_EN_O = q.gate;
  assign CORE_SYSTEM_CLOCK_SRC_O    = q.src;
  assign ADC_CLK_DIV_O   = q.adcdiv;
  assign PLL_CFG_O       = q.pllc;
  assign BOR_IRQ_O       = q.bint;
  assign WDT_IRQ_O       = q.wint;

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  bor_off_a: assert property (
    CE_I && !sys_rst && BOR_DET_I && !q.bor_sel && EXT_RST_N_I
    && !SYS_RESET_REQ_I && !q.wfire |=> !SYS_RST_O)
    else $error("brownout reset while not selected");
  bor_irq_a: assert property (
    CE_I && BOR_DET_I && !q.bor_prev && !q.bor_sel |=> BOR_IRQ_O)
    else $error("brownout interrupt missing");
  bor_hold_a: assert property (
    CE_I && BOR_DET_I && q.bor_sel |=> SYS_RST_O && q.cause[rcc_pkg::CAU_BOR])
    else $error("brownout reset not held or not recorded");
  srst_wr_a: assert property (
    wr && PADDR_I == rcc_pkg::SRST_OFF[0] && !sys_rst && !src_any
    |=> PERIPH_RST_O[31:0] == $past(PWDATA_I))
    else $error("peripheral reset does not follow register");
  gate_wr_a: assert property (
    wr && PADDR_I == rcc_pkg::GATE_OFF[1] && !sys_rst
    |=> PERIPH_CLK_EN_O[63:32] == $past(PWDATA_I))
    else $error("clock gate does not follow register");
  sysreq_a: assert property (
    CE_I && SYS_RESET_REQ_I |=> SYS_RST_O && q.cause[rcc_pkg::CAU_SW])
    else $error("core reset request ignored");
  rel_len_a: assert property (
    CE_I && q.st == rcc_pkg::ST_HOLD && !src_any |=> SYS_RST_O [*4])
    else $error("reset released too early");
  wd_first_a: assert property (
    CE_I && q.wen && q.wcnt == '0 && !q.wint && !sys_rst && !wr
    |=> WDT_IRQ_O && q.wcnt == $past(q.wload))
    else $error("watchdog first time-out wrong");
  wd_second_a: assert property (
    CE_I && q.wen && q.wcnt == '0 && q.wint && !sys_rst
    |=> q.wfire == $past(q.wren))
    else $error("watchdog second time-out wrong");
  clk_rst_a: assert property (
    SYS_RST_O |-> CORE_SYSTEM_CLOCK_SRC_O == rcc_pkg::SRC_INT)
    else $error("not on internal oscillator in reset");
  pll_lock_a: assert property (
    CE_I && !PLL_LOCK_I |=> CORE_SYSTEM_CLOCK_SRC_O != rcc_pkg::SRC_PLL)
    else $error("pll selected before lock");
  adc_div_a: assert property (
    CORE_SYSTEM_CLOCK_SRC_O == rcc_pkg::SRC_PLL |-> ADC_CLK_DIV_O == rcc_pkg::ADC_PLL_DIV)
    else $error("converter divider wrong");
  pll_cfg_a: assert property (
    CE_I && !wr && !sys_rst
    |=> PLL_CFG_O == pll_cfg(q.rcfg[rcc_pkg::CRYSTAL_SELECT_LSB +: rcc_pkg::CRYSTAL_SELECT_W]))
    else $error("pll setup does not follow crystal");
  sync_rel_a: assert property (
    $fell(SYS_RST_O) |-> $past(q.st) == rcc_pkg::ST_REL && $past(q.cnt) == '0)
    else $error("reset left outside release count");

  wd_reset_c: cover property (q.wfire ##1 SYS_RST_O);
  bor_irq_c: cover property (BOR_IRQ_O && !SYS_RST_O);
  pll_run_c: cover property (CORE_SYSTEM_CLOCK_SRC_O == rcc_pkg::SRC_PLL);

endmodule

// [bench/testbench.sv]
// self-checking testbench of the reset and clock control block
`timescale 1ns/100ps
module testbench;
  // ********************
  // signals
  // ********************
  logic                          clk;
  logic                          rst;
  logic                          ce;
  logic                          ext_rst_n;
  logic                          bor_det;
  logic                          sys_req;
  logic                          pll_lock;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [7:0]                    paddr;
  logic [31:0]                   pwdata;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          sys_rst;
  logic [rcc_pkg::NP_W-1:0]      periph_rst;
  logic [rcc_pkg::NP_W-1:0]      clk_en;
  logic [2:0]                    src;
  logic [7:0]                    adc_div;
  logic [rcc_pkg::PLLC_W-1:0]    pll_cfg;
  logic                          bor_irq;
  logic                          wdt_irq;
  logic [31:0]                   rd;
  logic                          err;
  logic [2:0]                    srcs [4];
  int                            fail_count;
  int                            total_checks;
  int                            n;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  reset_and_clock_control DUT (
    .CLK_I           (clk),
    .RST_I           (rst),
    .CE_I            (ce),
    .EXT_RST_N_I     (ext_rst_n),
    .BOR_DET_I       (bor_det),
    .SYS_RESET_REQ_I (sys_req),
    .PLL_LOCK_I      (pll_lock),
    .PSEL_I          (psel),
    .PENABLE_I       (penable),
    .PWRITE_I        (pwrite),
    .PADDR_I         (paddr),
    .PWDATA_I        (pwdata),
    .PRDATA_O        (prdata),
    .PREADY_O        (pready),
    .PSLVERR_O       (pslverr),
    .SYS_RST_O       (sys_rst),
    .PERIPH_RST_O    (periph_rst),
    .PERIPH_CLK_EN_O (clk_en),
    .CORE_SYSTEM_CLOCK_SRC_O    (src),
    .ADC_CLK_DIV_O   (adc_div),
    .PLL_CFG_O       (pll_cfg),
    .BOR_IRQ_O       (bor_irq),
    .WDT_IRQ_O       (wdt_irq)
  );

  // ********************
  // tasks
  // ********************
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic timeout(input string s);
    fail_count++;
    $display("[FAIL] %0t timeout waiting for %s", $time, s);
    final_report();
  endtask

  task automatic chk(input logic [95:0] got, input logic [95:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) timeout("pready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                       input string msg);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp, msg);
  endtask

  task automatic wait_sig(input logic sel, input logic v, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge clk);
      if ((sel ? wdt_irq : sys_rst) === v) break;
    end
    if (k == lim) timeout("reset or watchdog level");
  endtask

  function automatic logic [31:0] rcw(input logic [1:0] o,
                                      input logic [4:0] x,
                                      input logic b, input logic p);
    return {18'h0, p, 1'b0, b, x, o, 4'h0};
  endfunction

  // ********************
  // main sequence
  // ********************
  initial begin
    srcs = '{rcc_pkg::SRC_MAIN, rcc_pkg::SRC_INT, rcc_pkg::SRC_INT4,
             rcc_pkg::SRC_30K};
    fail_count = 0;
    total_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    ext_rst_n = 1'b1;
    bor_det = 1'b0;
    sys_req = 1'b0;
    pll_lock = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tick(1);
    chk(src, rcc_pkg::SRC_INT, "source in reset");
    chk(sys_rst, 1'b1, "reset in power-on");
    tick(5);
    rst <= 1'b0;
    wait_sig(1'b0, 1'b0, 20);
    chk(src, rcc_pkg::SRC_INT, "source after reset");
    rdchk(rcc_pkg::CAUSE_OFF, 32'(rcc_pkg::CAUSE_RST), "cause");
    rdchk(rcc_pkg::BRC_OFF, 32'h0000_0000, "brownout ctrl");
    rdchk(rcc_pkg::RCFG_OFF, rcc_pkg::RCFG_RST, "run cfg");
    rdchk(rcc_pkg::WLOAD_OFF, rcc_pkg::WLOAD_RST, "reload");
    rdchk(8'h40, 32'h0000_0000, "unmapped read");
    chk(err, 1'b1, "unmapped error");
    done("reset defaults");

    bor_det <= 1'b1;
    tick(3);
    chk(sys_rst, 1'b0, "brownout without select");
    chk(bor_irq, 1'b1, "brownout flag");
    bor_det <= 1'b0;
    apb(1'b1, rcc_pkg::STAT_OFF, 32'h0000_0002);
    tick(2);
    chk(bor_irq, 1'b0, "brownout flag cleared");
    apb(1'b1, rcc_pkg::CAUSE_OFF, 32'h0000_0000);
    apb(1'b1, rcc_pkg::BRC_OFF, 32'(1) << rcc_pkg::BOR_SEL);
    bor_det <= 1'b1;
    wait_sig(1'b0, 1'b1, 5);
    tick(10);
    chk(sys_rst, 1'b1, "held while supply low");
    bor_det <= 1'b0;
    wait_sig(1'b0, 1'b0, 20);
    rdchk(rcc_pkg::CAUSE_OFF, 32'(1) << rcc_pkg::CAU_BOR, "bor");
    rdchk(rcc_pkg::BRC_OFF, 32'(1) << rcc_pkg::BOR_SEL, "sel");
    apb(1'b1, rcc_pkg::BRC_OFF, 32'h0000_0000);
    done("brownout");

    for (int s = 0; s < 2; s++) begin
      apb(1'b1, rcc_pkg::CAUSE_OFF, 32'h0000_0000);
      @(posedge clk);
      if (s == 0) begin
        ext_rst_n <= 1'b0;
      end else begin
        sys_req <= 1'b1;
      end
      @(posedge clk);
      ext_rst_n <= 1'b1;
      sys_req <= 1'b0;
      n = 0;
      wait_sig(1'b0, 1'b1, 6);
      while (sys_rst === 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      chk(n, rcc_pkg::REL_CYC + 1, "release count");
      rdchk(rcc_pkg::CAUSE_OFF, (s == 0) ? 32'(1) << rcc_pkg::CAU_EXT :
            32'(1) << rcc_pkg::CAU_SW, "request cause");
    end
    done("pin and core request");

    for (int i = 0; i < rcc_pkg::NREG; i++) begin
      apb(1'b1, rcc_pkg::SRST_OFF[i], 32'h8000_0001);
      apb(1'b1, rcc_pkg::GATE_OFF[i], 32'h8000_0001);
      tick(2);
      chk(periph_rst, 96'h8000_0001 << (32 * i), "soft reset");
      chk(clk_en, 96'h8000_0001 << (32 * i), "gate");
      apb(1'b1, rcc_pkg::SRST_OFF[i], 32'h0000_0000);
      apb(1'b1, rcc_pkg::GATE_OFF[i], 32'h0000_0000);
      tick(2);
      chk(periph_rst, 96'h0, "soft reset released");
      chk(clk_en, 96'h0, "gate off");
    end
    done("peripheral reset and gates");

    apb(1'b1, rcc_pkg::CAUSE_OFF, 32'h0000_0000);
    apb(1'b1, rcc_pkg::WLOAD_OFF, 32'h0000_0010);
    apb(1'b1, rcc_pkg::WCTL_OFF, 32'h0000_0001);
    wait_sig(1'b1, 1'b1, 40);
    apb(1'b0, rcc_pkg::WVAL_OFF, 32'h0000_0000);
    chk(rd <= 32'h0000_0010, 1'b1, "counter reloaded");
    tick(40);
    chk(sys_rst, 1'b0, "no reset while disabled");
    apb(1'b1, rcc_pkg::WCTL_OFF, 32'h0000_0003);
    wait_sig(1'b0, 1'b1, 40);
    wait_sig(1'b0, 1'b0, 20);
    rdchk(rcc_pkg::CAUSE_OFF, 32'(1) << rcc_pkg::CAU_WDT, "wdt");
    done("watchdog");

    for (int o = 0; o < 4; o++) begin
      apb(1'b1, rcc_pkg::RCFG_OFF, rcw(2'(o), 5'h10, 1'b1, 1'b1));
      tick(2);
      chk(src, srcs[o], "raw source");
      chk(adc_div, rcc_pkg::ADC_RAW_DIV, "raw divider");
    end
    pll_lock <= 1'b1;
    apb(1'b1, rcc_pkg::RCFG_OFF, rcw(2'h0, 5'h0B, 1'b0, 1'b0));
    tick(2);
    chk(src, rcc_pkg::SRC_PLL, "pll source");
    chk(adc_div, rcc_pkg::ADC_PLL_DIV, "pll divider");
    chk(pll_cfg, {5'h0B, 9'(rcc_pkg::PLL_F_BASE - 9'h00B)}, "xl");
    pll_lock <= 1'b0;
    tick(3);
    chk(src, rcc_pkg::SRC_MAIN, "unlocked pll");
    apb(1'b1, rcc_pkg::RCFG2_OFF, 32'h8000_2870);
    tick(2);
    chk(src, rcc_pkg::SRC_RTC, "override");
    apb(1'b1, rcc_pkg::RCFG2_OFF, 32'h0000_2810);
    tick(2);
    chk(src, rcc_pkg::SRC_MAIN, "override off");
    done("clock steering");

    ce <= 1'b0;
    sys_req <= 1'b1;
    tick(3);
    chk(sys_rst, 1'b0, "request taken while frozen");
    chk(pready, 1'b0, "ready while frozen");
    sys_req <= 1'b0;
    ce <= 1'b1;
    tick(2);
    chk(sys_rst, 1'b0, "late reset after freeze");
    rdchk(rcc_pkg::CAUSE_OFF, 32'(1) << rcc_pkg::CAU_WDT, "frz");
    done("clock enable");
    final_report();
  end
endmodule
